/* File: rtl/pd_consts.svh */
// Purpose: shared constants for the palette converter pixel and host port
// Assumes: one 200 MHz clock for both ends
// Notes: times in ns, cycle counts derived from them
`ifndef PD_CONSTS_SVH
`define PD_CONSTS_SVH
`define PD_CLK_NS 5
// Least times round up to whole cycles
`define PD_CYC_UP(ns) (((ns) + `PD_CLK_NS - 1) / `PD_CLK_NS)
`define PD_T_SETUP_NS 35
`define PD_T_HOLD_NS 35
`define PD_T_HIGH_NS 25
`define PD_T_WRLOW_NS 50
`define PD_T_RDVALID_NS 100
`define PD_SETUP_CYC `PD_CYC_UP(`PD_T_SETUP_NS)
`define PD_HOLD_CYC `PD_CYC_UP(`PD_T_HOLD_NS)
`define PD_HIGH_CYC `PD_CYC_UP(`PD_T_HIGH_NS)
`define PD_WRLOW_CYC `PD_CYC_UP(`PD_T_WRLOW_NS)
`define PD_RDVALID_CYC `PD_CYC_UP(`PD_T_RDVALID_NS)
// Hidden component counter codes
`define PD_COMP_RED 2'h0
`define PD_COMP_GREEN 2'h1
`define PD_COMP_BLUE 2'h2
// Color word field positions
`define PD_RED_MSB 23
`define PD_RED_LSB 16
`define PD_GREEN_MSB 15
`define PD_GREEN_LSB 8
`define PD_BLUE_MSB 7
`define PD_BLUE_LSB 0
// Host controller register offsets
`define PD_REG_WRITE_BASE 3'h0
`define PD_REG_READ_CMD 3'h4
`define PD_REG_READ_DATA 3'h5
`define PD_BLACK 8'h00
`endif

/* File: rtl/pd_device.sv */
// Purpose: palette converter front end: pixel pipeline and host port
// Assumes: pixel and host signals come from logic on sys_clk
// Notes: color outputs are 8-bit codes for the converters
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "pd_consts.svh"
module pd_device (
	input wire logic sys_clk,
	input wire logic rstn,
	pd_if.device bus,
	input wire logic [7:0] pixelIndex,
	input wire logic [1:0] overlaySelect,
	input wire logic blankN,
	input wire logic syncN,
	output logic [7:0] colorRed,
	output logic [7:0] colorGreen,
	output logic [7:0] colorBlue,
	output logic syncCurrentOn
);
	// Storage; palette has no reset, as in the part
	pd_pkg::pd_color_t palette [0:255];
	pd_pkg::pd_color_t overlay [1:3];

	logic [7:0] pixReg, next_pixReg;
	logic [1:0] ovlReg, next_ovlReg;
	logic blankReg, next_blankReg;
	logic syncReg, next_syncReg;
	logic [7:0] next_colorRed, next_colorGreen, next_colorBlue;
	logic next_syncCurrentOn;

	logic [7:0] palettePointer, next_palettePointer;
	logic [1:0] componentCounter, next_componentCounter;
	logic [7:0] redHold, next_redHold;
	logic [7:0] greenHold, next_greenHold;
	logic [7:0] dataHold, next_dataHold;
	logic [1:0] cmdHold, next_cmdHold;
	logic wasWrite, next_wasWrite;
	logic wasRead, next_wasRead;
	logic [7:0] next_devData;
	logic next_devDriveEn;
	logic accWrite, accRead, writeEnd, readEnd;
	logic paletteWe, overlayWe;
	pd_pkg::pd_color_t pixColor, hostWord;

	// Component counter step; blue wraps back to red
	function automatic logic [1:0] pd_next_comp(input logic [1:0] comp);
		pd_next_comp = (comp == `PD_COMP_BLUE) ? `PD_COMP_RED : comp + 2'h1;
	endfunction : pd_next_comp

	// Byte of a color word picked by the component counter
	function automatic logic [7:0] pd_pick(input pd_pkg::pd_color_t w, input logic [1:0] comp);
		case (comp)
			`PD_COMP_RED: pd_pick = w[`PD_RED_MSB:`PD_RED_LSB];
			`PD_COMP_GREEN: pd_pick = w[`PD_GREEN_MSB:`PD_GREEN_LSB];
			default: pd_pick = w[`PD_BLUE_MSB:`PD_BLUE_LSB];
		endcase
	endfunction : pd_pick

	// Pixel pipeline: stage one registers inputs, stage two looks up color
	always_comb
	begin
		next_pixReg = pixelIndex;
		next_ovlReg = overlaySelect;
		next_blankReg = blankN;
		next_syncReg = syncN;
		// select 00 reads palette, others an overlay color
		if (ovlReg == 2'b00)
			pixColor = palette[pixReg];
		else
			pixColor = overlay[ovlReg];
		if (!bus.csN || !blankReg)
		begin
			// Black and blanking share code zero; analog offsets live downstream
			next_colorRed = `PD_BLACK;
			next_colorGreen = `PD_BLACK;
			next_colorBlue = `PD_BLACK;
		end
		else
		begin
			next_colorRed = pixColor[`PD_RED_MSB:`PD_RED_LSB];
			next_colorGreen = pixColor[`PD_GREEN_MSB:`PD_GREEN_LSB];
			next_colorBlue = pixColor[`PD_BLUE_MSB:`PD_BLUE_LSB];
		end
		// Sync never overrides color; the source keeps it inside blanking
		next_syncCurrentOn = syncReg;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			pixReg <= 8'h00;
			ovlReg <= 2'h0;
			blankReg <= 1'b0;
			syncReg <= 1'b0;
			colorRed <= 8'h00;
			colorGreen <= 8'h00;
			colorBlue <= 8'h00;
			syncCurrentOn <= 1'b0;
		end
		else
		begin
			pixReg <= next_pixReg;
			ovlReg <= next_ovlReg;
			blankReg <= next_blankReg;
			syncReg <= next_syncReg;
			colorRed <= next_colorRed;
			colorGreen <= next_colorGreen;
			colorBlue <= next_colorBlue;
			syncCurrentOn <= next_syncCurrentOn;
		end
	end

	// Host port: access windows, end detection, pointer and counter
	always_comb
	begin
		// All three low is illegal; it counts as neither access
		accWrite = !bus.csN && !bus.wrN && bus.rdN;
		accRead = !bus.csN && !bus.rdN && bus.wrN;
		// End of access is the first of strobe or select rising
		writeEnd = wasWrite && !accWrite;
		readEnd = wasRead && !accRead;
		next_wasWrite = accWrite;
		next_wasRead = accRead;
		// Data held from the last cycle of the window; zero hold time is safe
		next_dataHold = accWrite ? bus.hostBus : dataHold;
		next_cmdHold = (accWrite || accRead) ? bus.commandLines : cmdHold;
		next_palettePointer = palettePointer;
		next_componentCounter = componentCounter;
		next_redHold = redHold;
		next_greenHold = greenHold;
		paletteWe = 1'b0;
		overlayWe = 1'b0;
		if (writeEnd)
		begin
			if (!cmdHold[0])
			begin
				next_palettePointer = dataHold;
				next_componentCounter = `PD_COMP_RED;
			end
			else
			begin
				case (componentCounter)
					`PD_COMP_RED: next_redHold = dataHold;
					`PD_COMP_GREEN: next_greenHold = dataHold;
					default:
					begin
						paletteWe = !cmdHold[1];
						// Overlay index zero is reserved and drops the word
						overlayWe = cmdHold[1] && (palettePointer[1:0] != 2'b00);
						next_palettePointer = palettePointer + 8'h01;
					end
				endcase
				next_componentCounter = pd_next_comp(componentCounter);
			end
		end
		else if (readEnd && cmdHold[0])
		begin
			// Reading the pointer leaves the counter alone
			if (componentCounter == `PD_COMP_BLUE)
				next_palettePointer = palettePointer + 8'h01;
			next_componentCounter = pd_next_comp(componentCounter);
		end
		// Read data from the live command lines
		if (!bus.commandLines[1])
			hostWord = palette[palettePointer];
		else if (palettePointer[1:0] == 2'b00)
			hostWord = 24'h00_0000;
		else
			hostWord = overlay[palettePointer[1:0]];
		if (!bus.commandLines[0])
			next_devData = palettePointer;
		else
			next_devData = pd_pick(hostWord, componentCounter);
		next_devDriveEn = accRead;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			palettePointer <= 8'h00;
			componentCounter <= `PD_COMP_RED;
			redHold <= 8'h00;
			greenHold <= 8'h00;
			dataHold <= 8'h00;
			cmdHold <= 2'h0;
			wasWrite <= 1'b0;
			wasRead <= 1'b0;
			bus.devData <= 8'h00;
			bus.devDriveEn <= 1'b0;
		end
		else
		begin
			palettePointer <= next_palettePointer;
			componentCounter <= next_componentCounter;
			redHold <= next_redHold;
			greenHold <= next_greenHold;
			dataHold <= next_dataHold;
			cmdHold <= next_cmdHold;
			wasWrite <= next_wasWrite;
			wasRead <= next_wasRead;
			bus.devData <= next_devData;
			bus.devDriveEn <= next_devDriveEn;
		end
	end

	// Color store; 24-bit word committed on the blue write
	always_ff @(posedge sys_clk)
	begin
		if (paletteWe)
			palette[palettePointer] <= {redHold, greenHold, dataHold};
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			overlay[1] <= 24'h00_0000;
			overlay[2] <= 24'h00_0000;
			overlay[3] <= 24'h00_0000;
		end
		else if (overlayWe)
			overlay[palettePointer[1:0]] <= {redHold, greenHold, dataHold};
	end
endmodule : pd_device

/* File: rtl/pd_host.sv */
// Purpose: host end driving the converter's asynchronous port
// Assumes: software port on sys_clk, read data one cycle after strobe
// Notes: one access at a time; launches while busy are dropped
`timescale 1ns/1ps
`include "pd_consts.svh"
module pd_host (
	input wire logic sys_clk,
	input wire logic rstn,
	pd_if.host bus,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	output logic busy
);
	pd_pkg::pd_host_state_t state, next_state;
	logic [5:0] cnt, next_cnt;
	logic isRead, next_isRead;
	logic [7:0] readByte, next_readByte;
	logic [7:0] next_regRdData;
	logic next_busy;
	logic next_csN, next_rdN, next_wrN, next_hostDriveEn;
	logic [1:0] next_commandLines;
	logic [7:0] next_hostData;
	logic launchWr, launchRd;

	// Access sequencer: setup, strobe, hold, recovery gap
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_isRead = isRead;
		next_readByte = readByte;
		next_csN = bus.csN;
		next_rdN = bus.rdN;
		next_wrN = bus.wrN;
		next_hostDriveEn = bus.hostDriveEn;
		next_commandLines = bus.commandLines;
		next_hostData = bus.hostData;
		launchWr = regWrStb && !regAddr[2];
		launchRd = regWrStb && (regAddr == `PD_REG_READ_CMD);
		case (state)
			pd_pkg::HS_IDLE:
				if (launchWr || launchRd)
				begin
					next_csN = 1'b0;
					next_commandLines = launchWr ? regAddr[1:0] : regWrData[1:0];
					next_hostData = regWrData;
					next_hostDriveEn = launchWr;
					next_isRead = launchRd;
					next_cnt = 6'(`PD_SETUP_CYC - 1);
					next_state = pd_pkg::HS_SETUP;
				end
			pd_pkg::HS_SETUP:
				if (cnt == 6'h00)
				begin
					// Only one strobe ever falls, never both
					next_rdN = !isRead;
					next_wrN = isRead;
					next_cnt = isRead ? 6'(`PD_RDVALID_CYC - 1) : 6'(`PD_WRLOW_CYC - 1);
					next_state = pd_pkg::HS_STROBE;
				end
				else
					next_cnt = cnt - 6'h01;
			pd_pkg::HS_STROBE:
				if (cnt == 6'h00)
				begin
					next_rdN = 1'b1;
					next_wrN = 1'b1;
					if (isRead)
						next_readByte = bus.hostBus;
					next_cnt = 6'(`PD_HOLD_CYC - 1);
					next_state = pd_pkg::HS_HOLD;
				end
				else
					next_cnt = cnt - 6'h01;
			pd_pkg::HS_HOLD:
				if (cnt == 6'h00)
				begin
					next_csN = 1'b1;
					next_hostDriveEn = 1'b0;
					next_cnt = 6'(`PD_HIGH_CYC - 1);
					next_state = pd_pkg::HS_GAP;
				end
				else
					next_cnt = cnt - 6'h01;
			pd_pkg::HS_GAP:
				if (cnt == 6'h00)
					next_state = pd_pkg::HS_IDLE;
				else
					next_cnt = cnt - 6'h01;
			default:
				next_state = pd_pkg::HS_IDLE;
		endcase
		// Register read port
		if (regRdStb && regAddr == `PD_REG_READ_DATA)
			next_regRdData = readByte;
		else if (regRdStb && regAddr == `PD_REG_READ_CMD)
			next_regRdData = {7'h00, state != pd_pkg::HS_IDLE};
		else
			next_regRdData = 8'h00;
		// Busy mirrors the sequencer so software sees the launch at once
		next_busy = (next_state != pd_pkg::HS_IDLE);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			state <= pd_pkg::HS_IDLE;
			cnt <= 6'h00;
			isRead <= 1'b0;
			readByte <= 8'h00;
			regRdData <= 8'h00;
			busy <= 1'b0;
			bus.csN <= 1'b1;
			bus.rdN <= 1'b1;
			bus.wrN <= 1'b1;
			bus.hostDriveEn <= 1'b0;
			bus.commandLines <= 2'h0;
			bus.hostData <= 8'h00;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			isRead <= next_isRead;
			readByte <= next_readByte;
			regRdData <= next_regRdData;
			busy <= next_busy;
			bus.csN <= next_csN;
			bus.rdN <= next_rdN;
			bus.wrN <= next_wrN;
			bus.hostDriveEn <= next_hostDriveEn;
			bus.commandLines <= next_commandLines;
			bus.hostData <= next_hostData;
		end
	end
endmodule : pd_host

/* File: rtl/pd_if.sv */
// Purpose: host port wires between host and palette converter
// Assumes: both ends on sys_clk
// Notes: shared data bus resolved here from the two enables
`timescale 1ns/1ps
interface pd_if;
	logic csN;
	logic rdN;
	logic wrN;
	logic [1:0] commandLines;
	logic [7:0] hostData;
	logic hostDriveEn;
	logic [7:0] devData;
	logic devDriveEn;
	logic [7:0] hostBus;

	// Bus level; an undriven bus reads as zero
	assign hostBus = hostDriveEn ? hostData : (devDriveEn ? devData : 8'h00);

	modport device (
		input csN, rdN, wrN, commandLines, hostBus,
		output devData, devDriveEn
	);
	modport host (
		output csN, rdN, wrN, commandLines, hostData, hostDriveEn,
		input hostBus
	);
endinterface : pd_if

/* File: rtl/pd_pkg.sv */
// Purpose: types shared by both ends
// Assumes: pd_consts.svh holds the numbers
// Notes: none
package pd_pkg;
	typedef logic [23:0] pd_color_t;
	typedef enum logic [4:0] {
		HS_IDLE = 5'b0_0001,
		HS_SETUP = 5'b0_0010,
		HS_STROBE = 5'b0_0100,
		HS_HOLD = 5'b0_1000,
		HS_GAP = 5'b1_0000
	} pd_host_state_t;
endpackage : pd_pkg

/* File: verification/pd_chk.sv */
// Purpose: checks on the host port wires and pixel outputs
// Assumes: one clock, synchronous active-low reset
// Notes: instantiated beside the interface, no bind
`timescale 1ns/1ps
module pd_chk (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic csN,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic [1:0] commandLines,
	input wire logic hostDriveEn,
	input wire logic devDriveEn,
	input wire logic blankN,
	input wire logic syncN,
	input wire logic [7:0] colorRed,
	input wire logic [7:0] colorGreen,
	input wire logic [7:0] colorBlue,
	input wire logic syncCurrentOn
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic dark;
	// All three codes at zero; black and blanking share it
	assign dark = (colorRed == 8'h00) && (colorGreen == 8'h00) && (colorBlue == 8'h00);
	// Pipeline is two edges deep
	property p_blank;
		!blankN |-> ##2 dark;
	endproperty
	a_blank: assert property (p_blank) else $error("blank did not darken");
	property p_syncOn;
		syncN |-> ##2 syncCurrentOn;
	endproperty
	a_syncOn: assert property (p_syncOn) else $error("sync current missing");
	property p_syncOff;
		!syncN |-> ##2 !syncCurrentOn;
	endproperty
	a_syncOff: assert property (p_syncOff) else $error("sync current stuck");
	property p_csBlack;
		!csN |=> dark;
	endproperty
	a_csBlack: assert property (p_csBlack) else $error("colors during access");
	property p_devDrive;
		devDriveEn == $past(!csN && !rdN && wrN);
	endproperty
	a_devDrive: assert property (p_devDrive) else $error("bus drive off window");
	property p_oneDriver;
		!(devDriveEn && hostDriveEn);
	endproperty
	a_oneDriver: assert property (p_oneDriver) else $error("bus contention");
	property p_notAllLow;
		csN || rdN || wrN;
	endproperty
	a_notAllLow: assert property (p_notAllLow) else $error("all strobes low");
	property p_wrLow;
		$fell(wrN) |-> !csN && rdN ##1 !wrN [*8];
	endproperty
	a_wrLow: assert property (p_wrLow) else $error("short write strobe");
	property p_rdCs;
		!rdN |-> !csN;
	endproperty
	a_rdCs: assert property (p_rdCs) else $error("read without select");
	property p_cmdHeld;
		!csN && $past(!csN) |-> $stable(commandLines);
	endproperty
	a_cmdHeld: assert property (p_cmdHeld) else $error("command moved");
	c_write: cover property ($rose(wrN) && !csN);
	c_read: cover property (!csN && !rdN);
	c_blank: cover property (!blankN ##2 dark);
endmodule : pd_chk

/* File: verification/tb.sv */
// Purpose: self-checking bench for host and converter ends
// Assumes: software port reaches the converter through the host end
// Notes: palette and overlay written, read back and shown on pixels
`timescale 1ns/1ps
module tb;
	logic sys_clk;
	logic rstn;
	logic [2:0] regAddr;
	logic [7:0] regWrData;
	logic regWrStb;
	logic regRdStb;
	logic [7:0] regRdData;
	logic busy;
	logic [7:0] pixelIndex;
	logic [1:0] overlaySelect;
	logic blankN;
	logic syncN;
	logic [7:0] colorRed, colorGreen, colorBlue;
	logic syncCurrentOn;
	int failures;
	int n_compared;
	pd_if link ();
	pd_device u_pd_device (.sys_clk(sys_clk), .rstn(rstn), .bus(link),
		.pixelIndex(pixelIndex), .overlaySelect(overlaySelect), .blankN(blankN),
		.syncN(syncN), .colorRed(colorRed), .colorGreen(colorGreen),
		.colorBlue(colorBlue), .syncCurrentOn(syncCurrentOn));
	pd_host u_pd_host (.sys_clk(sys_clk), .rstn(rstn), .bus(link), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .busy(busy));
	pd_chk u_pd_chk (.sys_clk(sys_clk), .rstn(rstn), .csN(link.csN), .rdN(link.rdN),
		.wrN(link.wrN), .commandLines(link.commandLines), .hostDriveEn(link.hostDriveEn),
		.devDriveEn(link.devDriveEn), .blankN(blankN), .syncN(syncN),
		.colorRed(colorRed), .colorGreen(colorGreen), .colorBlue(colorBlue),
		.syncCurrentOn(syncCurrentOn));
	// 200 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// Strobe only; the caller decides whether to wait
	task automatic launch(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge sys_clk);
		regWrStb <= 1'b0;
	endtask : launch
	// Bounded poll; a hung access counts as a mismatch
	task automatic idle_wait();
		int i;
		i = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			i++;
		end
		while (busy !== 1'b0 && i < 100);
		if (busy !== 1'b0)
		begin
			failures++;
			$display("wrong value at %0t: busy %h expected %h", $time, busy, 1'b0);
		end
	endtask : idle_wait
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		launch(a, d);
		idle_wait();
	endtask : reg_wr
	task automatic reg_rd(input logic [1:0] c, input logic [23:0] exp);
		reg_wr(3'h4, {6'h00, c});
		@(posedge sys_clk);
		regAddr <= 3'h5;
		regRdStb <= 1'b1;
		@(posedge sys_clk);
		regRdStb <= 1'b0;
		#1;
		check({16'h0000, regRdData}, exp);
	endtask : reg_rd
	// Inputs held, result two edges on
	task automatic pix(input logic [7:0] idx, input logic [1:0] ovl, input logic bl,
		input logic sy, input logic [23:0] exp);
		@(posedge sys_clk);
		pixelIndex <= idx;
		overlaySelect <= ovl;
		blankN <= bl;
		syncN <= sy;
		repeat (2) @(posedge sys_clk);
		#1;
		check({colorRed, colorGreen, colorBlue}, exp);
		check({23'h00_0000, syncCurrentOn}, {23'h00_0000, sy});
	endtask : pix
	task automatic t_palette();
		reg_wr(3'h0, 8'hff);
		reg_wr(3'h1, 8'h12);
		reg_wr(3'h1, 8'h34);
		reg_wr(3'h1, 8'h56);
		reg_rd(2'h0, 24'h00_0000);
		reg_wr(3'h0, 8'hff);
		reg_rd(2'h1, 24'h00_0012);
		reg_rd(2'h1, 24'h00_0034);
		reg_rd(2'h1, 24'h00_0056);
		reg_rd(2'h0, 24'h00_0000);
	endtask : t_palette
	task automatic t_overlay();
		reg_wr(3'h0, 8'hfd);
		reg_wr(3'h3, 8'ha1);
		reg_wr(3'h3, 8'hb2);
		reg_wr(3'h3, 8'hc3);
		pix(8'hff, 2'h1, 1'b1, 1'b1, 24'ha1_b2c3);
		pix(8'hff, 2'h2, 1'b1, 1'b1, 24'h00_0000);
		pix(8'hff, 2'h3, 1'b1, 1'b1, 24'h00_0000);
		// Upper pointer bits set on purpose; only the low two pick the overlay
		reg_wr(3'h0, 8'h05);
		reg_rd(2'h3, 24'h00_00a1);
		reg_rd(2'h3, 24'h00_00b2);
		reg_rd(2'h3, 24'h00_00c3);
	endtask : t_overlay
	task automatic t_cs_black();
		pix(8'hff, 2'h0, 1'b1, 1'b1, 24'h12_3456);
		launch(3'h4, 8'h01);
		repeat (15) @(posedge sys_clk);
		#1;
		check({colorRed, colorGreen, colorBlue}, 24'h00_0000);
		// Status read while the bus access is still running
		@(posedge sys_clk);
		regAddr <= 3'h4;
		regRdStb <= 1'b1;
		@(posedge sys_clk);
		regRdStb <= 1'b0;
		#1;
		check({16'h0000, regRdData}, 24'h00_0001);
		idle_wait();
	endtask : t_cs_black
	task automatic wrap_up();
		$display("failures=%0d compared=%0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	// Main sequence
	initial
	begin
		failures = 0;
		n_compared = 0;
		rstn = 1'b0;
		regAddr = 3'h0;
		regWrData = 8'h00;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
		pixelIndex = 8'h00;
		overlaySelect = 2'h0;
		blankN = 1'b1;
		syncN = 1'b1;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		t_palette();
		pix(8'hff, 2'h0, 1'b1, 1'b1, 24'h12_3456);
		pix(8'hff, 2'h0, 1'b0, 1'b0, 24'h00_0000);
		t_overlay();
		t_cs_black();
		wrap_up();
	end
	// Run needs about 730 cycles
	initial
	begin
		#50000;
		failures++;
		wrap_up();
	end
endmodule : tb
